// file: fpws_defs.svh
// constant definitions for the flash page wear and ecc status block
`ifndef FPWS_DEFS_SVH
`define FPWS_DEFS_SVH
`define FPWS_ADDR_CTRL      8'h00
`define FPWS_ADDR_PAGE_SEL  8'h04
`define FPWS_ADDR_COUNT     8'h08
`define FPWS_ADDR_STATUS    8'h0C
`define FPWS_ADDR_RAW       8'h10
`define FPWS_ADDR_IRQ_STAT  8'h14
`define FPWS_ADDR_IRQ_MASK  8'h18
`define FPWS_ADDR_IR_CAP    8'h1C
`define FPWS_CNT_START      16'h08F0
`define FPWS_THRESH_STEP    16'h1000
`define FPWS_THRESH_MULT    3
`define FPWS_CODE_WORN      2'h3
`define FPWS_CODE_OK        2'h0
`define FPWS_IRQ_WIDTH      4
`define FPWS_IRQ_SINGLE_BIT_CORRECTABLE_ERROR       0
`define FPWS_IRQ_MULTI_BIT_UNCORRECTABLE_ERROR       1
`define FPWS_IRQ_WORN       2
`define FPWS_IRQ_WRAP       3
`define FPWS_IR_DONE_BIT    2
`define FPWS_IR_BASE        8'h51
`endif

// file: fpws_pkg.sv
// types for the flash page wear and ecc status block
package fpws_pkg;
   typedef struct packed
   {
      logic [1:0]  code;
      logic        single_bit_correctable_error_status;
      logic        multi_bit_uncorrectable_error_status;
      logic        single_bit_correctable_error_data;
      logic        multi_bit_uncorrectable_error_data;
      logic        prot;
   } fpws_page_flags_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_OP   = 3'b010,
      ST_ACK  = 3'b100
   } fpws_state_t;
endpackage

// file: fpws_core.sv
// per-page wear counter, ecc classification and ir capture with wishbone registers
// Overview of operation
// - counters start at 2288, not zero
// - each program or erase adds one
// - threshold is 12288, a multiple of 4096
// - past threshold, later operations force code 11
// - single-bit error: correctable class, data corrected
// - multi-bit error: uncorrectable class, no correction
// - status and data checked separately, own results
// - bad count never blocks programming
// - ir capture value includes done bit
// - done bit one when the synchronized and filtered array_done is high
`timescale 1ns/1ps
`default_nettype none
`include "fpws_defs.svh"

module fpws_core #(
   parameter int PAGES = 16,
   parameter int PW    = 4
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic [31:0]        wb_dat_o,
   input  wire logic          wb_we_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   output logic               wb_ack_o,
   input  wire logic          op_valid,
   input  wire logic [PW-1:0] op_page,
   input  wire logic          ecc_valid,
   input  wire logic [PW-1:0] ecc_page,
   input  wire logic          ecc_on_status,
   input  wire logic [1:0]    ecc_err_bits,
   input  wire logic [31:0]   ecc_word,
   input  wire logic [31:0]   ecc_flip,
   input  wire logic          prot_in,
   output logic [31:0]        corrected_word,
   output logic               corrected_valid,
   input  wire logic          array_done,
   output logic [7:0]         ir_capture,
   output logic               irq
);

   //////////////////////////////////////////////////////////////////////////////
   // page store
   localparam logic [15:0] THRESH = 16'(`FPWS_THRESH_MULT * `FPWS_THRESH_STEP);
   logic [15:0]             cnt_q   [PAGES];
   logic [15:0]             cnt_d   [PAGES];
   fpws_pkg::fpws_page_flags_t flg_q [PAGES];
   fpws_pkg::fpws_page_flags_t flg_d [PAGES];
   logic [3:0]              ist_q, ist_d, imask_q, imask_d;
   logic [PW-1:0]           sel_q, sel_d;
   logic                    prot_clr;
   logic                    wr_hit, rd_hit;
   logic [31:0]             raw_word;

   // a write lands on the edge where the master sees ack, never earlier
   assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   always_comb
   begin
      logic [3:0] ev;
      ev = 4'h0;
      for (int i = 0; i < PAGES; i++)
      begin
         cnt_d[i] = cnt_q[i];
         flg_d[i] = flg_q[i];
      end
      // clear goes first so a protection report in the same cycle wins
      if (prot_clr)
         flg_d[sel_q].prot = 1'b0;
      // no gate on count validity: a bad count never blocks the operation
      if (op_valid)
      begin
         cnt_d[op_page] = cnt_q[op_page] + 16'h0001;
         if (cnt_q[op_page] == 16'hFFFF)
            ev[`FPWS_IRQ_WRAP] = 1'b1;
         if (cnt_q[op_page] > THRESH)
         begin
            flg_d[op_page].code = `FPWS_CODE_WORN;
            ev[`FPWS_IRQ_WORN] = 1'b1;
         end
      end
      if (ecc_valid)
      begin
         flg_d[ecc_page].prot = prot_in;
         if (ecc_on_status)
         begin
            flg_d[ecc_page].single_bit_correctable_error_status = (ecc_err_bits == 2'h1);
            flg_d[ecc_page].multi_bit_uncorrectable_error_status = (ecc_err_bits >= 2'h2);
         end
         else
         begin
            flg_d[ecc_page].single_bit_correctable_error_data = (ecc_err_bits == 2'h1);
            flg_d[ecc_page].multi_bit_uncorrectable_error_data = (ecc_err_bits >= 2'h2);
         end
         ev[`FPWS_IRQ_SINGLE_BIT_CORRECTABLE_ERROR] = (ecc_err_bits == 2'h1);
         ev[`FPWS_IRQ_MULTI_BIT_UNCORRECTABLE_ERROR] = (ecc_err_bits >= 2'h2);
      end
      ist_d   = ist_q;
      imask_d = imask_q;
      sel_d   = sel_q;
      if (wr_hit && wb_sel_i[0])
      begin
         case (wb_adr_i)
            `FPWS_ADDR_PAGE_SEL: sel_d   = wb_dat_i[PW-1:0];
            `FPWS_ADDR_IRQ_MASK: imask_d = wb_dat_i[3:0];
            `FPWS_ADDR_IRQ_STAT: ist_d   = ist_q & ~wb_dat_i[3:0];
            default:             ;
         endcase
      end
      ist_d = ist_d | ev; // set wins over clear
   end

   assign prot_clr = wr_hit && wb_sel_i[0] && wb_adr_i == `FPWS_ADDR_CTRL && wb_dat_i[0];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < PAGES; i++)
         begin
            cnt_q[i] <= `FPWS_CNT_START;
            flg_q[i] <= '0;
         end
         ist_q   <= 4'h0;
         imask_q <= 4'h0;
         sel_q   <= '0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         flg_q   <= flg_d;
         ist_q   <= ist_d;
         imask_q <= imask_d;
         sel_q   <= sel_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // ecc correction path: only single-bit words are repaired
   logic [31:0] corr_d;
   always_comb
   begin
      corr_d = ecc_word;
      if (ecc_err_bits == 2'h1)
         corr_d = ecc_word ^ ecc_flip;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         corrected_word  <= 32'h0000_0000;
         corrected_valid <= 1'b0;
      end
      else
      begin
         corrected_word  <= corr_d;
         corrected_valid <= ecc_valid && !ecc_on_status && ecc_err_bits < 2'h2;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // ir capture and interrupt
   logic done_s1, done_s2, done_s3, done_q;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
         done_q  <= 1'b0;
         ir_capture <= `FPWS_IR_BASE;
      end
      else
      begin
         done_s1 <= array_done;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         if (done_s2 == done_s3)
            done_q <= done_s3;
         ir_capture <= `FPWS_IR_BASE | {5'h00, done_q, 2'h0};
      end
   end

   assign irq = |(ist_q & imask_q);

   //////////////////////////////////////////////////////////////////////////////
   // wishbone slave, one wait-free cycle, unmapped reads zero
   fpws_pkg::fpws_page_flags_t fs;
   logic [31:0] rd_d;
   assign fs       = flg_q[sel_q];
   assign rd_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign raw_word = {cnt_q[sel_q], 9'h000, fs};

   always_comb
   begin
      case (wb_adr_i)
         `FPWS_ADDR_PAGE_SEL: rd_d = 32'(sel_q);
         `FPWS_ADDR_COUNT:    rd_d = {16'h0000, cnt_q[sel_q]};
         `FPWS_ADDR_STATUS:   rd_d = {25'h000_0000, fs};
         `FPWS_ADDR_RAW:      rd_d = raw_word;
         `FPWS_ADDR_IRQ_STAT: rd_d = {28'h000_0000, ist_q};
         `FPWS_ADDR_IRQ_MASK: rd_d = {28'h000_0000, imask_q};
         `FPWS_ADDR_IR_CAP:   rd_d = {24'h00_0000, ir_capture};
         default:             rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= rd_hit;
         wb_dat_o <= rd_hit ? rd_d : wb_dat_o;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // checks
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      op_valid && !(ecc_valid) |=> cnt_q[$past(op_page)] == $past(cnt_q[op_page]) + 16'h0001)
      else $error("count did not step by one");
   worn_code_a: assert property (@(posedge clk) disable iff (rst)
      op_valid && cnt_q[op_page] > THRESH |=> flg_q[$past(op_page)].code == 2'h3)
      else $error("worn page code not 11");
   worn_irq_a: assert property (@(posedge clk) disable iff (rst)
      op_valid && cnt_q[op_page] > THRESH |=> ist_q[`FPWS_IRQ_WORN])
      else $error("worn event not recorded");
   single_bit_correctable_error_class_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && !ecc_on_status && ecc_err_bits == 2'h1
      |=> flg_q[$past(ecc_page)].single_bit_correctable_error_data && !flg_q[$past(ecc_page)].multi_bit_uncorrectable_error_data)
      else $error("single error not correctable class");
   single_bit_correctable_error_repair_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && !ecc_on_status && ecc_err_bits == 2'h1
      |=> corrected_valid && corrected_word == $past(ecc_word ^ ecc_flip))
      else $error("single error word not repaired");
   multi_bit_uncorrectable_error_class_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && ecc_err_bits >= 2'h2 |=> ist_q[1] && !corrected_valid)
      else $error("multi error not uncorrectable");
   multi_bit_uncorrectable_error_untouched_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && ecc_err_bits >= 2'h2 |=> corrected_word == $past(ecc_word))
      else $error("multi error word was altered");
   split_check_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && ecc_on_status && !op_valid
      |=> flg_q[$past(ecc_page)].multi_bit_uncorrectable_error_data == $past(flg_q[ecc_page].multi_bit_uncorrectable_error_data))
      else $error("status check touched data result");
   no_block_a: assert property (@(posedge clk) disable iff (rst)
      op_valid |=> cnt_q[$past(op_page)] != $past(cnt_q[op_page]))
      else $error("operation blocked");
   done_bit_a: assert property (@(posedge clk) disable iff (rst)
      array_done [*8] |=> ##[0:2] ir_capture[2])
      else $error("done bit missing");
   ir_base_a: assert property (@(posedge clk) disable iff (rst)
      !done_q |=> ir_capture == `FPWS_IR_BASE)
      else $error("done bit shown while not done");
   raw_word_a: assert property (@(posedge clk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == `FPWS_ADDR_RAW
      |=> wb_ack_o && wb_dat_o == {$past(cnt_q[sel_q]), 9'h000, $past(flg_q[sel_q])})
      else $error("raw word readout mismatch");
   start_val_a: assert property (@(posedge clk)
      $past(rst) |-> cnt_q[0] == `FPWS_CNT_START)
      else $error("counter start wrong");
   irq_lvl_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && ecc_err_bits == 2'h1 && imask_q[0] && !wr_hit |=> irq)
      else $error("irq level wrong");
   irq_sticky_a: assert property (@(posedge clk) disable iff (rst)
      ist_q[`FPWS_IRQ_SINGLE_BIT_CORRECTABLE_ERROR] && !(wr_hit && wb_adr_i == `FPWS_ADDR_IRQ_STAT)
      |=> ist_q[`FPWS_IRQ_SINGLE_BIT_CORRECTABLE_ERROR])
      else $error("status bit dropped without clear");
   mask_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_hit && wb_sel_i[0] && wb_adr_i == `FPWS_ADDR_IRQ_MASK
      |=> imask_q == $past(wb_dat_i[3:0]))
      else $error("mask write lost");
   prot_wins_a: assert property (@(posedge clk) disable iff (rst)
      ecc_valid && prot_in |=> flg_q[$past(ecc_page)].prot)
      else $error("protection report lost");
   ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse");
   wb_ack_c: cover property (@(posedge clk) disable iff (rst) wb_ack_o && !wb_we_i);
   worn_c: cover property (@(posedge clk) disable iff (rst) op_valid && cnt_q[op_page] > THRESH);
   single_bit_correctable_error_c: cover property (@(posedge clk) disable iff (rst) corrected_valid && ist_q[0]);
   prot_clr_c: cover property (@(posedge clk) disable iff (rst) prot_clr);
   done_c: cover property (@(posedge clk) disable iff (rst) ir_capture[2]);
endmodule
`default_nettype wire

// file: fpws_reader.sv
// debug reader model judging the raw page status word
`timescale 1ns/1ps
`default_nettype none

module fpws_reader #(
   parameter int RET_LIMIT = 12288
) (
   input  wire logic [31:0] raw,
   input  wire logic        variant,
   output logic             cnt_ok,
   output logic             worn,
   output logic             prot_bad
);
   // variant 0 needs 6384, variant 1 needs 2288
   assign cnt_ok   = raw[31:16] >= (variant ? 16'h08F0 : 16'h18F0);
   assign worn     = raw[31:16] > RET_LIMIT[15:0];
   // every set protection flag is taken as illegal here
   assign prot_bad = raw[0];
endmodule
`default_nettype wire

// file: tb.sv
// testbench for the flash page wear and ecc status block
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk, rst, we, cyc, stb, ack, opv, eccv, ecs, prot, done, cv, irq;
   logic        vsel, ok, wrn, pb;
   logic [7:0]  adr, irc;
   logic [31:0] di, dq, cw, rd, raw, ew, ef;
   logic [3:0]  opg, eg, sl;
   logic [1:0]  eb;
   int          error_cnt, samples_checked, cyc_n;

   fpws_core fpws_core_i (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(di), .wb_dat_o(dq),
      .wb_we_i(we), .wb_sel_i(sl), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
      .op_valid(opv), .op_page(opg), .ecc_valid(eccv), .ecc_page(eg), .ecc_on_status(ecs),
      .ecc_err_bits(eb), .ecc_word(ew), .ecc_flip(ef), .prot_in(prot), .corrected_word(cw),
      .corrected_valid(cv), .array_done(done), .ir_capture(irc), .irq(irq));
   fpws_reader fpws_reader_i (.raw(raw), .variant(vsel), .cnt_ok(ok), .worn(wrn), .prot_bad(pb));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // holds the request until ack is seen, one idle cycle before
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      sl  <= 4'hF;
      we  <= w;
      adr <= a;
      di  <= d;
      // ack and read data are taken as they stood at the rising edge
      @(posedge clk);
      while (ack !== 1'h1)
         @(posedge clk);
      rd = dq;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask

   task automatic ecc(input logic [3:0] p, input logic s, input logic [1:0] b, input logic pr);
      @(posedge clk);
      eccv <= 1'h1;
      eg   <= p;
      ecs  <= s;
      eb   <= b;
      prot <= pr;
      @(posedge clk);
      eccv <= 1'h0;
      prot <= 1'h0;
      @(negedge clk);
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'h0;
      forever
         #25 clk = ~clk;
   end

   // whole run needs about 10100 cycles
   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n == 30000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   initial
   begin
      {we, cyc, stb, opv, eccv, ecs, prot, done} = '0;
      rst = 1'h1;
      vsel = 1'h1;
      adr = '0;
      di = '0;
      opg = '0;
      eg = '0;
      eb = '0;
      sl = '0;
      raw = '0;
      ew = 32'hA5A5_0F0F;
      ef = 32'h0000_0100;
      error_cnt = 0;
      samples_checked = 0;
      cyc_n = 0;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      wb(1'h0, 8'h08, '0);
      chk("count", 32'h0000_08F0, rd);
      chk("ir", 32'h0000_0051, {24'h00_0000, irc});
      opv <= 1'h1;
      repeat (3) @(posedge clk);
      opv <= 1'h0;
      wb(1'h0, 8'h08, '0);
      chk("count", 32'h0000_08F3, rd);
      ecc(4'h0, 1'h0, 2'h1, 1'h1);
      chk("corr_word", ew ^ ef, cw);
      chk("corr_valid", 32'h0000_0001, {31'h0, cv});
      ecc(4'h0, 1'h1, 2'h2, 1'h1);
      wb(1'h0, 8'h0C, '0);
      chk("flags", 32'h0000_000D, rd);
      wb(1'h0, 8'h10, '0);
      raw <= rd;
      @(negedge clk);
      chk("raw", 32'h08F3_000D, rd);
      chk("cnt_ok", 32'h0000_0001, {31'h0, ok});
      chk("worn", 32'h0000_0000, {31'h0, wrn});
      chk("prot_bad", 32'h0000_0001, {31'h0, pb});
      vsel <= 1'h0;
      @(negedge clk);
      chk("cnt_ok", 32'h0000_0000, {31'h0, ok});
      wb(1'h1, 8'h00, 32'h0000_0001);
      wb(1'h0, 8'h0C, '0);
      chk("flags", 32'h0000_000C, rd);
      ecc(4'h0, 1'h0, 2'h3, 1'h0);
      chk("corr_valid", 32'h0000_0000, {31'h0, cv});
      chk("corr_word", ew, cw);
      wb(1'h1, 8'h18, 32'h0000_0003);
      ecc(4'h2, 1'h0, 2'h1, 1'h0);
      wb(1'h0, 8'h14, '0);
      chk("irq_stat", 32'h0000_0003, rd);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wb(1'h1, 8'h14, 32'h0000_0003);
      wb(1'h0, 8'h14, '0);
      chk("irq_stat", 32'h0000_0000, rd);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      wb(1'h0, 8'h20, '0);
      chk("unmapped", 32'h0000_0000, rd);
      done <= 1'h1;
      repeat (8) @(posedge clk);
      chk("ir", 32'h0000_0055, {24'h00_0000, irc});
      wb(1'h1, 8'h04, 32'h0000_0001);
      opg <= 4'h1;
      opv <= 1'h1;
      repeat (10001) @(posedge clk);
      opv <= 1'h0;
      wb(1'h0, 8'h08, '0);
      chk("count", 32'h0000_3001, rd);
      wb(1'h0, 8'h0C, '0);
      chk("flags", 32'h0000_0000, rd);
      opv <= 1'h1;
      @(posedge clk);
      opv <= 1'h0;
      wb(1'h0, 8'h10, '0);
      raw <= rd;
      @(negedge clk);
      chk("raw", 32'h3002_0060, rd);
      chk("worn", 32'h0000_0001, {31'h0, wrn});
      chk("cnt_ok", 32'h0000_0001, {31'h0, ok});
      wb(1'h0, 8'h14, '0);
      chk("irq_stat", 32'h0000_0004, rd);
      wb(1'h0, 8'h1C, '0);
      chk("ir_reg", 32'h0000_0055, rd);
      complete_run();
   end
endmodule
`default_nettype wire
